// File: oss_ctrl.v
// oss_ctrl.v: serial command/status shift logic of an eight-channel load switch
// assumes spi pins, enable and direct drive inputs are asynchronous to clk_i;
// fault inputs come from the power stage on the same clock
// Overview of operation
// - while select low, drive data out and shift both directions
// - apply the received command only on rising edge of select
// - sample data in on each falling serial clock edge while selected
// - advance data out to next bit on each rising serial clock edge
// - select high: ignore clock and data in, data out high impedance
// - command msb first: open-load enables 8..1 then outputs 8..1
// - each transfer is a 16-bit command and 16-bit status, msb first
// - command bit zero turns output off, one turns it on
// - status one means fault, zero means normal, any configuration
// - off output with open-load current disabled reports no open load
// - first eight bits out are zero, then status channel 8 first
// - shift register is fifo; input bits emerge after sixteen clocks
// - daisy chain shifts every clock; outputs update on select rise
// - enable low turns outputs off, disables open-load current, sleeps
// - power-on reset on enable rise and on supply application
// - outputs five and six are command bit or direct drive input
// - status word shows previous fault state, not the new command
// - command bits 8 to 15 enable open-load current channels 1 to 8
// - after reset or sleep, outputs off and open-load currents off
// - status bit set for short to battery, ground, off-state open load, overtemp
`timescale 1ns/1ps
`default_nettype none
`include "oss_map.vh"

module oss_ctrl #(
    parameter integer WORD_BITS = `OSS_WORD_BITS,
    parameter integer CH_NUM = `OSS_CH_NUM,
    parameter integer POR_US = `OSS_POR_US,
    parameter integer CLK_MHZ = `OSS_CLK_MHZ,
    parameter integer POR_CYCLES = POR_US * CLK_MHZ
) (
    input wire clk_i,
    input wire rst_n_i,
    input wire chip_select_n_i,
    input wire serial_clock_i,
    input wire serial_data_in_i,
    output reg serial_data_out_o,
    output reg serial_data_out_oe_o,
    input wire enable_i,
    input wire supply_ok_i,
    input wire direct_drive_input_a_i,
    input wire direct_drive_input_b_i,
    input wire [CH_NUM-1:0] short_battery_i,
    input wire [CH_NUM-1:0] short_ground_i,
    input wire [CH_NUM-1:0] open_load_i,
    input wire [CH_NUM-1:0] over_temp_i,
    output reg [CH_NUM-1:0] output_on_o,
    output reg [CH_NUM-1:0] open_load_current_o,
    output reg spi_ready_o
);
    // two-stage synchronisers; logic reads the second stage, edge detects also a third
    reg cs_m_q, cs_s_q, cs_p_q;
    reg sck_m_q, sck_s_q, sck_p_q;
    reg sdi_m_q, sdi_s_q;
    reg en_m_q, en_s_q, en_p_q;
    reg sup_m_q, sup_s_q, sup_p_q;
    reg dda_m_q, dda_s_q, ddb_m_q, ddb_s_q;
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            cs_m_q <= 1'b1;
            cs_s_q <= 1'b1;
            cs_p_q <= 1'b1;
            sck_m_q <= 1'b0;
            sck_s_q <= 1'b0;
            sck_p_q <= 1'b0;
            sdi_m_q <= 1'b0;
            sdi_s_q <= 1'b0;
            en_m_q <= 1'b0;
            en_s_q <= 1'b0;
            en_p_q <= 1'b0;
            sup_m_q <= 1'b0;
            sup_s_q <= 1'b0;
            sup_p_q <= 1'b0;
            dda_m_q <= 1'b0;
            dda_s_q <= 1'b0;
            ddb_m_q <= 1'b0;
            ddb_s_q <= 1'b0;
        end else begin
            cs_m_q <= chip_select_n_i;
            cs_s_q <= cs_m_q;
            cs_p_q <= cs_s_q;
            sck_m_q <= serial_clock_i;
            sck_s_q <= sck_m_q;
            sck_p_q <= sck_s_q;
            sdi_m_q <= serial_data_in_i;
            sdi_s_q <= sdi_m_q;
            en_m_q <= enable_i;
            en_s_q <= en_m_q;
            en_p_q <= en_s_q;
            sup_m_q <= supply_ok_i;
            sup_s_q <= sup_m_q;
            sup_p_q <= sup_s_q;
            dda_m_q <= direct_drive_input_a_i;
            dda_s_q <= dda_m_q;
            ddb_m_q <= direct_drive_input_b_i;
            ddb_s_q <= ddb_m_q;
        end
    end

    wire awake = en_s_q & sup_s_q;
    wire selected = ~cs_s_q & awake;
    wire cs_fall = cs_p_q & ~cs_s_q;
    wire cs_rise = ~cs_p_q & cs_s_q;
    wire sck_rise = ~sck_p_q & sck_s_q;
    wire sck_fall = sck_p_q & ~sck_s_q;
    // a rising enable or supply starts power-on reset
    wire por_start = (en_s_q & ~en_p_q) | (sup_s_q & ~sup_p_q);

    // power-on reset timer; serial port is dead until it expires
    reg [31:0] por_cnt_q;
    reg por_busy_q;
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            por_cnt_q <= 32'h0000_0000;
            por_busy_q <= 1'b1;
        end else if (!awake || por_start) begin
            por_cnt_q <= 32'h0000_0000;
            por_busy_q <= 1'b1;
        end else if (por_busy_q) begin
            if (por_cnt_q >= POR_CYCLES - 1)
                por_busy_q <= 1'b0;
            por_cnt_q <= por_cnt_q + 32'h0000_0001;
        end
    end
    wire live = selected & ~por_busy_q;

    // raw per-channel fault, gated by open-load current for off outputs
    wire [CH_NUM-1:0] fault_now;
    genvar g;
    generate
        for (g = 0; g < CH_NUM; g = g + 1) begin : g_flt
            // off-state open load only counts with its detect current on
            assign fault_now[g] = short_battery_i[g] | short_ground_i[g] | over_temp_i[g] |
                (open_load_i[g] & ~output_on_o[g] & open_load_current_o[g]);
        end
    endgenerate

    // one fifo register serves both directions, so chains pass data through
    reg [WORD_BITS-1:0] shift_q;
    reg [WORD_BITS-1:0] cmd_q;
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            shift_q <= `OSS_CMD_RESET;
            serial_data_out_o <= 1'b0;
            serial_data_out_oe_o <= 1'b0;
        end else if (!live) begin
            // clock and data in ignored while deselected
            serial_data_out_oe_o <= 1'b0;
            serial_data_out_o <= 1'b0;
        end else begin
            serial_data_out_oe_o <= 1'b1;
            if (cs_fall) begin
                // status snapshot predates the new command
                shift_q <= {`OSS_CH_ZERO, fault_now};
                serial_data_out_o <= 1'b0;
            end else begin
                if (sck_rise)
                    serial_data_out_o <= shift_q[WORD_BITS-1];
                if (sck_fall)
                    shift_q <= {shift_q[WORD_BITS-2:0], sdi_s_q};
            end
        end
    end

    // command register: loaded on select rise, cleared by reset, sleep or power-on reset
    always @(posedge clk_i) begin
        if (!rst_n_i || !awake || por_busy_q)
            cmd_q <= `OSS_CMD_RESET;
        else if (cs_rise)
            cmd_q <= shift_q;
    end

    // output stage; channels five and six ored with direct drives
    reg [CH_NUM-1:0] out_d;
    always @* begin
        out_d = cmd_q[`OSS_OUT_LSB +: CH_NUM];
        out_d[4] = out_d[4] | dda_s_q;
        out_d[5] = out_d[5] | ddb_s_q;
    end
    always @(posedge clk_i) begin
        if (!rst_n_i || !awake || por_busy_q) begin
            output_on_o <= `OSS_CH_ZERO;
            open_load_current_o <= `OSS_CH_ZERO;
            spi_ready_o <= 1'b0;
        end else begin
            output_on_o <= out_d;
            open_load_current_o <= cmd_q[`OSS_OLD_LSB +: CH_NUM];
            spi_ready_o <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// File: oss_map.vh
// oss_map.vh: constants for the octal switch serial control block
// assumes inclusion by bare name from the design file
`ifndef OSS_MAP_VH
`define OSS_MAP_VH
`define OSS_WORD_BITS 16
`define OSS_CH_NUM 8
`define OSS_OLD_LSB 8
`define OSS_OUT_LSB 0
`define OSS_CMD_RESET 16'h0000
`define OSS_CH_ZERO 8'h00
`define OSS_POR_US 100
`define OSS_CLK_MHZ 40
`endif

// File: oss_chk_asserts.sv
// port checker for oss_ctrl
// bound to every oss_ctrl instance, sees its ports only
`timescale 1ns/1ps
`default_nettype none
module oss_chk (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic chip_select_n_i,
    input wire logic serial_clock_i,
    input wire logic serial_data_out_o,
    input wire logic serial_data_out_oe_o,
    input wire logic enable_i,
    input wire logic direct_drive_input_a_i,
    input wire logic [7:0] output_on_o,
    input wire logic [7:0] open_load_current_o,
    input wire logic spi_ready_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // windows allow for the two-flop pin sync
    a_dout_tristate: assert property (chip_select_n_i [*4] |-> !serial_data_out_oe_o)
        else $error("dout driven while idle");
    a_dout_driven: assert property ((!chip_select_n_i && spi_ready_o) [*5] |-> serial_data_out_oe_o)
        else $error("dout not driven in frame");
    a_apply_at_rise: assert property ((!chip_select_n_i && enable_i) [*8] |-> $stable(output_on_o & 8'hcf))
        else $error("outputs moved in frame");
    a_sleep_off: assert property (!enable_i [*4] |-> !spi_ready_o && output_on_o == 8'h00 && open_load_current_o == 8'h00)
        else $error("awake while disabled");
    a_reset_clear: assert property (disable iff (1'b0) !rst_n_i |=> output_on_o == 8'h00 && !serial_data_out_oe_o)
        else $error("reset did not clear");
    a_dout_steady: assert property ((!chip_select_n_i && $stable(serial_clock_i)) [*8] |-> $stable(serial_data_out_o))
        else $error("dout moved without clock edge");
    a_direct_or: assert property ((enable_i && spi_ready_o && direct_drive_input_a_i) [*5] |-> output_on_o[4])
        else $error("direct drive not ored");
    a_ready_delay: assert property ($rose(enable_i) |-> !spi_ready_o [*8])
        else $error("ready before power-on delay");
    cover property ($rose(chip_select_n_i));
    cover property ($fell(spi_ready_o));
    cover property (output_on_o[4] && direct_drive_input_a_i);
endmodule
bind oss_ctrl oss_chk i_oss_chk (.*);
`default_nettype wire

// File: oss_spi_master.sv
// spi master model for oss_ctrl, one 16-bit word per call
// assumes clk_i is the bench clock; sck half period is 4 clocks
`timescale 1ns/1ps
`default_nettype none
module oss_spi_master (
    input wire logic clk_i,
    input wire logic miso_i,
    output logic cs_n_o,
    output logic sck_o,
    output logic mosi_o
);
    initial begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        mosi_o = 1'b0;
    end
    // keep_sel leaves select low so a second word can follow in a chain
    task automatic xfer(input logic [15:0] cmd, input logic keep_sel, output logic [15:0] sts);
        cs_n_o <= 1'b0;
        repeat (8) @(posedge clk_i);
        for (int i = 15; i >= 0; i--) begin
            sck_o <= 1'b1;
            mosi_o <= cmd[i];
            repeat (4) @(posedge clk_i);
            sts[i] = miso_i;
            sck_o <= 1'b0;
            repeat (4) @(posedge clk_i);
        end
        cs_n_o <= ~keep_sel;
        mosi_o <= ~mosi_o; // a released line must not show a stale bit
        repeat (8) @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

// File: tb_oss_ctrl.sv
// self-checking bench for oss_ctrl
// assumes a 40 MHz clock and a short power-on count
`timescale 1ns/1ps
`default_nettype none
module tb_oss_ctrl;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic enable_i = 1'b1;
    logic supply_ok_i = 1'b1;
    logic dda = 1'b0;
    logic ddb = 1'b0;
    logic [7:0] sg = 8'h00;
    logic [7:0] sb = 8'h00;
    logic [7:0] ol = 8'h00;
    logic [7:0] ot = 8'h00;
    logic [15:0] sts;
    wire cs_n, sck, mosi, dout, oe, rdy;
    wire [7:0] outs, olc;
    wire miso = oe ? dout : 1'bz;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;
    oss_ctrl #(.POR_CYCLES(20)) i_oss_ctrl (.clk_i(clk_i), .rst_n_i(rst_n_i), .chip_select_n_i(cs_n),
        .serial_clock_i(sck), .serial_data_in_i(mosi), .serial_data_out_o(dout), .serial_data_out_oe_o(oe),
        .enable_i(enable_i), .supply_ok_i(supply_ok_i), .direct_drive_input_a_i(dda), .direct_drive_input_b_i(ddb),
        .short_battery_i(sb), .short_ground_i(sg), .open_load_i(ol), .over_temp_i(ot),
        .output_on_o(outs), .open_load_current_o(olc), .spi_ready_o(rdy));
    oss_spi_master i_oss_spi_master (.clk_i(clk_i), .miso_i(miso), .cs_n_o(cs_n), .sck_o(sck), .mosi_o(mosi));
    initial forever #12.5 clk_i = ~clk_i;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        if (miscompares == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wait_ready;
        for (int n = 0; n < 200 && rdy !== 1'b1; n++) @(posedge clk_i);
        chk({15'h0000, rdy}, 16'h0001);
        chk({olc, outs}, 16'h0000);
    endtask
    task automatic frame(input logic [15:0] cmd, input logic [15:0] exp_sts, input logic [15:0] exp_out);
        i_oss_spi_master.xfer(cmd, 1'b0, sts);
        chk(sts, exp_sts);
        chk({olc, outs}, exp_out);
    endtask
    task automatic t_command;
        frame(16'h00a5, 16'h0000, 16'h00a5);
        frame(16'h5a3c, 16'h0000, 16'h5a3c);
        frame(16'h1000, 16'h0000, 16'h1000);
    endtask
    task automatic t_fault;
        sb <= 8'h81;
        ot <= 8'h04;
        ol <= 8'h30;
        sg <= 8'h02;
        repeat (4) @(posedge clk_i);
        frame(16'h0000, 16'h0097, 16'h0000);
        frame(16'h0000, 16'h0087, 16'h0000);
        sb <= 8'h00;
        sg <= 8'h00;
        ot <= 8'h00;
        ol <= 8'h00;
        repeat (4) @(posedge clk_i);
    endtask
    task automatic t_chain;
        i_oss_spi_master.xfer(16'h1234, 1'b1, sts);
        chk(sts, 16'h0000);
        i_oss_spi_master.xfer(16'h00c3, 1'b0, sts);
        chk(sts, 16'h1234);
        chk({olc, outs}, 16'h00c3);
    endtask
    task automatic t_direct;
        dda <= 1'b1; // command bits for channels five and six stay zero
        repeat (8) @(posedge clk_i);
        chk({olc, outs}, 16'h00d3);
        ddb <= 1'b1;
        repeat (8) @(posedge clk_i);
        chk({olc, outs}, 16'h00f3);
        dda <= 1'b0;
        ddb <= 1'b0;
        repeat (8) @(posedge clk_i);
        chk({olc, outs}, 16'h00c3);
    endtask
    task automatic t_sleep;
        enable_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        chk({olc, outs}, 16'h0000);
        chk({15'h0000, rdy}, 16'h0000);
        enable_i <= 1'b1;
        wait_ready();
        frame(16'hff00, 16'h0000, 16'hff00);
        supply_ok_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        supply_ok_i <= 1'b1;
        wait_ready();
    endtask
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            give_verdict();
        end
    end
    initial begin
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        wait_ready();
        t_command();
        t_fault();
        t_chain();
        t_direct();
        t_sleep();
        give_verdict();
    end
endmodule
`default_nettype wire
